// >>> hw/rpi_defs.svh
// Register map, field positions, reset values and timing for the relay panel block
// Overview of operation
// - With latching on and button-function switch 3 set, the reset button alone releases the latched trip output and keeps stored values.
// - With latching on and button-function switch 2 set, the step button alone releases the latched trip output and keeps stored values.
// - Indicator mode weights 1, 2, 4 and 8 select manual reset for low start, low trip, high start and high trip LEDs; a clear weight means self reset.
// - The indicator mode resets to 10 (starts self reset, trips manual); all four weights give 15.
// - The button-function group resets to 0 and only its three lowest switches act; switches four to eight are ignored.
// - The first three button-function switches select what step and reset do; both buttons together always clear LEDs, release latch, erase memory.
// - The indicator mode group is submenu 3 and the button-function group submenu 4 under the main selector group.
// - An eight-switch routing group sends switches 1 to 3 to auto-reclose start routing and switches 4 to 8 to stage blocking.
// - The measured value is shown on the three right digits with one LED naming the quantity shown.
// - Residual voltage is shown in percent of rated voltage and overflows above 25 percent.
// - A negative directional current shows a red minus sign on the leftmost digit.
// - A directional current above 100 percent shows an overflow pattern chosen by its sign.
// - Neutral current is shown in percent of the rated current of the energized input.
`ifndef RPI_DEFS_SVH
`define RPI_DEFS_SVH

`define RPI_ADDR_W        8
`define RPI_OFF_MAIN_SEL  8'h00
`define RPI_OFF_IND_MODE  8'h04
`define RPI_OFF_BTN_FUNC  8'h08
`define RPI_OFF_ROUTING   8'h0C
`define RPI_OFF_MENU_IDX  8'h10
`define RPI_OFF_MENU_DATA 8'h14
`define RPI_OFF_DISP_SEL  8'h18
`define RPI_OFF_STATUS    8'h1C

`define RPI_IND_MODE_RST  4'hA
`define RPI_BTN_FUNC_RST  8'h00
`define RPI_MAIN_SEL_RST  8'h00
`define RPI_ROUTING_RST   8'h00
`define RPI_LATCH_BIT     3
`define RPI_SUBMENU_MAIN  3'h0
`define RPI_SUBMENU_IND   3'h3
`define RPI_SUBMENU_BTN   3'h4
`define RPI_AR_LSB        0
`define RPI_AR_W          3
`define RPI_BLK_LSB       3
`define RPI_BLK_W         5

`define RPI_U0_OVF_PCT    10'h019
`define RPI_IPHI_OVF_PCT  10'h064

`define RPI_CLK_HZ        40000000
`define RPI_DEB_TIME_MS   5
`define RPI_DEB_CYCLES    ((`RPI_DEB_TIME_MS * `RPI_CLK_HZ) / 1000)

`endif

// >>> hw/rpi_pkg.sv
// Types shared by the relay panel block
package rpi_pkg;

	typedef enum logic [1:0] {DISP_U0, DISP_I0, DISP_IPHI} rpi_disp_e;

	typedef struct packed {
		logic clear;
		logic unlatch;
		logic erase;
	} rpi_act_s;

	typedef struct packed {
		logic [7:0]  main_sel;
		logic [3:0]  ind_mode;
		logic [7:0]  btn_func;
		logic [7:0]  routing;
		logic [2:0]  menu_idx;
		rpi_disp_e   disp_sel;
		logic [3:0]  led;
		logic        held;
		logic        trip_out;
		logic        erase;
		logic [9:0]  disp_val;
		logic        disp_neg;
		logic        disp_ovf;
		logic [2:0]  qled;
		logic [31:0] rdata;
	} rpi_state_s;

endpackage : rpi_pkg

// >>> hw/rpi_debounce.sv
// Push-button debouncer with one-cycle press pulse
`timescale 1ns/100ps
module rpi_debounce #(
	parameter int DEB_CYCLES = 200000
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic raw,
	output logic      level,
	output logic      press
);
	localparam int CW = $clog2(DEB_CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          stable;
		logic          press;
	} rpi_deb_s;

	rpi_deb_s deb_reg;
	rpi_deb_s deb_next;

	// Refuse a count the counter cannot serve
	if (DEB_CYCLES < 1)
	begin : g_bad_deb
		$error("DEB_CYCLES must be at least 1");
	end

	always_comb
	begin
		deb_next = deb_reg;
		deb_next.press = 1'b0;
		if (raw == deb_reg.stable)
			deb_next.cnt = '0;
		else if (deb_reg.cnt == CW'(DEB_CYCLES - 1))
		begin
			deb_next.cnt = '0;
			deb_next.stable = raw;
			deb_next.press = raw;
		end
		else
			deb_next.cnt = deb_reg.cnt + CW'(1);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			deb_reg <= '0;
		else
			deb_reg <= deb_next;
	end

	assign level = deb_reg.stable;
	assign press = deb_reg.press;

endmodule : rpi_debounce

// >>> hw/rpi_top.sv
// Relay panel indicator, button, routing and display logic
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "rpi_defs.svh"
module rpi_top
	import rpi_pkg::*;
#(
	parameter int DEB_CYCLES = `RPI_DEB_CYCLES
) (
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire logic [`RPI_ADDR_W-1:0] addr,
	input  wire logic [31:0]            wdata,
	input  wire logic                   wr,
	input  wire logic                   rd,
	output logic      [31:0]            rdata,
	input  wire logic                   step_btn,
	input  wire logic                   reset_btn,
	input  wire logic                   start_lo,
	input  wire logic                   trip_lo,
	input  wire logic                   start_hi,
	input  wire logic                   trip_hi,
	input  wire logic [9:0]             residual_voltage,
	input  wire logic [9:0]             neutral_current,
	input  wire logic signed [10:0]     dir_current,
	output logic      [3:0]             ind_led,
	output logic                        trip_out,
	output logic                        erase_mem,
	output logic      [`RPI_AR_W-1:0]   ar_start_route,
	output logic      [`RPI_BLK_W-1:0]  block_route,
	output logic      [9:0]             disp_value,
	output logic                        disp_minus,
	output logic                        disp_overflow,
	output logic      [2:0]             quantity_led
);
	rpi_state_s st_reg;
	rpi_state_s st_next;
	logic [1:0] btn_raw;
	logic [1:0] btn_level;
	logic [1:0] btn_press;
	logic       step_only;
	logic       rst_only;
	logic       both_btn;
	logic       latch_en;
	logic       trip_any;
	logic [3:0] events;
	rpi_act_s   act;

	// Refuse debounce counts outside the served range
	if (DEB_CYCLES < 1 || DEB_CYCLES > 1000000)
	begin : g_bad_deb
		$error("DEB_CYCLES out of range");
	end

	assign btn_raw = {reset_btn, step_btn};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_btn
			rpi_debounce #(
				.DEB_CYCLES (DEB_CYCLES)
			) u_deb (
				.clk   (clk),
				.reset (reset),
				.raw   (btn_raw[gi]),
				.level (btn_level[gi]),
				.press (btn_press[gi])
			);
		end
	endgenerate

	assign both_btn  = (btn_press[0] & btn_level[1]) | (btn_press[1] & btn_level[0]);
	assign step_only = btn_press[0] & ~btn_level[1];
	assign rst_only  = btn_press[1] & ~btn_level[0];

	function automatic rpi_act_s btn_action(
		input logic [2:0] f,
		input logic       stp,
		input logic       rst,
		input logic       bth
	);
		rpi_act_s a;
		a = '0;
		if (bth)
			a = '{clear: 1'b1, unlatch: 1'b1, erase: 1'b1};
		else if (rst)
		begin
			a.clear = 1'b1;
			a.unlatch = f[2];
		end
		else if (stp)
		begin
			a.clear = f[0] | f[1];
			a.unlatch = f[1];
		end
		return a;
	endfunction : btn_action

	assign act      = btn_action(st_reg.btn_func[2:0], step_only, rst_only, both_btn);
	assign latch_en = st_reg.main_sel[`RPI_LATCH_BIT];
	assign trip_any = trip_lo | trip_hi;
	assign events   = {trip_hi, start_hi, trip_lo, start_lo};

	always_comb
	begin
		logic [10:0] mag;
		mag = '0;
		st_next = st_reg;
		st_next.erase = act.erase;
		st_next.rdata = '0;

		if (wr)
		begin
			unique case (addr)
				`RPI_OFF_MAIN_SEL: st_next.main_sel = wdata[7:0];
				`RPI_OFF_IND_MODE: st_next.ind_mode = wdata[3:0];
				`RPI_OFF_BTN_FUNC: st_next.btn_func = wdata[7:0];
				`RPI_OFF_ROUTING:  st_next.routing = wdata[7:0];
				`RPI_OFF_MENU_IDX: st_next.menu_idx = wdata[2:0];
				`RPI_OFF_MENU_DATA:
				begin
					if (st_reg.menu_idx == `RPI_SUBMENU_IND)
						st_next.ind_mode = wdata[3:0];
					else if (st_reg.menu_idx == `RPI_SUBMENU_BTN)
						st_next.btn_func = wdata[7:0];
					else if (st_reg.menu_idx == `RPI_SUBMENU_MAIN)
						st_next.main_sel = wdata[7:0];
				end
				`RPI_OFF_DISP_SEL:
				begin
					if (wdata[1:0] != 2'h3)
						st_next.disp_sel = rpi_disp_e'(wdata[1:0]);
				end
				default: ;
			endcase
		end

		if (rd)
		begin
			unique case (addr)
				`RPI_OFF_MAIN_SEL: st_next.rdata = {24'h000000, st_reg.main_sel};
				`RPI_OFF_IND_MODE: st_next.rdata = {28'h0000000, st_reg.ind_mode};
				`RPI_OFF_BTN_FUNC: st_next.rdata = {24'h000000, st_reg.btn_func};
				`RPI_OFF_ROUTING:  st_next.rdata = {24'h000000, st_reg.routing};
				`RPI_OFF_MENU_IDX: st_next.rdata = {29'h00000000, st_reg.menu_idx};
				`RPI_OFF_MENU_DATA:
				begin
					if (st_reg.menu_idx == `RPI_SUBMENU_IND)
						st_next.rdata = {28'h0000000, st_reg.ind_mode};
					else if (st_reg.menu_idx == `RPI_SUBMENU_BTN)
						st_next.rdata = {24'h000000, st_reg.btn_func};
					else if (st_reg.menu_idx == `RPI_SUBMENU_MAIN)
						st_next.rdata = {24'h000000, st_reg.main_sel};
				end
				`RPI_OFF_DISP_SEL: st_next.rdata = {30'h00000000, st_reg.disp_sel};
				`RPI_OFF_STATUS:
					st_next.rdata = {26'h0000000, st_reg.held, st_reg.trip_out, st_reg.led};
				default: ;
			endcase
		end

		// manual LEDs hold, self LEDs follow; set wins
		for (int i = 0; i < 4; i++)
			st_next.led[i] = events[i] | (st_reg.ind_mode[i] & st_reg.led[i] & ~act.clear);

		st_next.held = latch_en & (trip_any | (st_reg.held & ~act.unlatch));
		st_next.trip_out = trip_any | st_next.held;

		st_next.disp_neg = 1'b0;
		st_next.disp_ovf = 1'b0;
		unique case (st_reg.disp_sel)
			DISP_U0:
			begin
				st_next.disp_val = residual_voltage;
				st_next.disp_ovf = residual_voltage > `RPI_U0_OVF_PCT;
				st_next.qled = 3'h1;
			end
			DISP_I0:
			begin
				st_next.disp_val = neutral_current;
				st_next.qled = 3'h2;
			end
			DISP_IPHI:
			begin
				// sign and signed overflow
				// Eleven bits so full-scale negative still overflows
				mag = dir_current[10] ? 11'(-dir_current) : 11'(dir_current);
				st_next.disp_val = mag[9:0];
				st_next.disp_neg = dir_current[10];
				st_next.disp_ovf = mag > 11'(`RPI_IPHI_OVF_PCT);
				st_next.qled = 3'h4;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			st_reg <= '0;
			st_reg.ind_mode <= `RPI_IND_MODE_RST;
			st_reg.btn_func <= `RPI_BTN_FUNC_RST;
			st_reg.main_sel <= `RPI_MAIN_SEL_RST;
			st_reg.routing <= `RPI_ROUTING_RST;
			st_reg.disp_sel <= DISP_U0;
			st_reg.qled <= 3'h1;
		end
		else
			st_reg <= st_next;
	end

	assign rdata          = st_reg.rdata;
	assign ind_led        = st_reg.led;
	assign trip_out       = st_reg.trip_out;
	assign erase_mem      = st_reg.erase;
	assign ar_start_route = st_reg.routing[`RPI_AR_LSB +: `RPI_AR_W];
	assign block_route    = st_reg.routing[`RPI_BLK_LSB +: `RPI_BLK_W];
	assign disp_value     = st_reg.disp_val;
	assign disp_minus     = st_reg.disp_neg;
	assign disp_overflow  = st_reg.disp_ovf;
	assign quantity_led   = st_reg.qled;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence seq_menu_ind_write;
		wr && addr == `RPI_OFF_MENU_DATA && st_reg.menu_idx == `RPI_SUBMENU_IND;
	endsequence

	sequence seq_read_back;
		rd && addr == `RPI_OFF_IND_MODE && !wr;
	endsequence

	AST_MENU_IND: assert property (seq_menu_ind_write ##1 seq_read_back |=>
		rdata[3:0] == $past(wdata[3:0], 2))
		else $error("submenu 3 write not seen in indicator mode");

	AST_RST_RELEASE: assert property (latch_en && st_reg.btn_func[2] && rst_only
		&& !trip_any && !wr |=> !trip_out && !erase_mem)
		else $error("reset button did not release latch cleanly");

	AST_STEP_RELEASE: assert property (latch_en && st_reg.btn_func[1] && step_only
		&& !trip_any && !wr |=> !trip_out && !erase_mem)
		else $error("step button did not release latch cleanly");

	AST_SELF_RESET: assert property (!st_reg.ind_mode[0] && !wr |=>
		ind_led[0] == $past(start_lo))
		else $error("self reset LED did not follow start");

	AST_MANUAL_HOLD: assert property (ind_led[1] && st_reg.ind_mode[1] && !act.clear
		|=> ind_led[1])
		else $error("manual LED dropped without clear");

	AST_DEFAULT_MODE: assert property ($fell(reset) |-> st_reg.ind_mode == 4'hA
		&& st_reg.btn_func == 8'h00)
		else $error("switch group defaults wrong");

	AST_ERASE_BOTH: assert property (erase_mem |-> $past(both_btn))
		else $error("memory erased without both buttons");

	AST_UPPER_IGNORED: assert property (step_only && st_reg.btn_func[1:0] == 2'h0
		&& !trip_any |=> !erase_mem && st_reg.held == $past(st_reg.held && latch_en))
		else $error("step alone acted beyond clearing");

	AST_U0_OVF: assert property (st_reg.disp_sel == DISP_U0 && residual_voltage > 10'd25
		|=> disp_overflow && quantity_led == 3'h1)
		else $error("voltage overflow missing");

	AST_MINUS: assert property (st_reg.disp_sel == DISP_IPHI && dir_current < 0
		|=> disp_minus)
		else $error("minus sign missing");

	AST_IPHI_OVF: assert property (st_reg.disp_sel == DISP_IPHI && dir_current > 11'sd100
		|=> disp_overflow && !disp_minus)
		else $error("positive overflow pattern wrong");

	AST_READ_WINDOW: assert property (!rd |=> rdata == 32'h00000000)
		else $error("read data outside its cycle");

	AST_BOTH_ERASE: assert property (both_btn |=> erase_mem)
		else $error("both buttons did not erase memory");

	AST_LATCH_HOLD: assert property (latch_en && st_reg.held && !act.unlatch
		|=> trip_out)
		else $error("latched trip dropped without release");

	AST_ROUTE: assert property (wr && addr == `RPI_OFF_ROUTING |=>
		ar_start_route == $past(wdata[2:0]) && block_route == $past(wdata[7:3]))
		else $error("routing fields wrong after write");

	AST_I0_VALUE: assert property (st_reg.disp_sel == DISP_I0 |=>
		disp_value == $past(neutral_current) && !disp_overflow && quantity_led == 3'h2)
		else $error("neutral current display wrong");

endmodule : rpi_top

// >>> test/rpi_operator_model.sv
// Operator at the panel: buttons that chatter on every change
`timescale 1ns/100ps
module rpi_operator_model (
	input  wire logic clk,
	input  wire logic want_step,
	input  wire logic want_reset,
	output logic      step_btn,
	output logic      reset_btn
);
	logic [1:0] want;
	logic [1:0] want_q       = 2'h0;
	logic [1:0] cnt [2]      = '{2'h0, 2'h0};
	logic [1:0] btn;

	assign want = {want_step, want_reset};
	assign step_btn = btn[1];
	assign reset_btn = btn[0];

	// Three cycles of contact chatter after each change
	always @(posedge clk)
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (want[i] != want_q[i])
				cnt[i] <= 2'h3;
			else if (cnt[i] != 2'h0)
				cnt[i] <= cnt[i] - 2'h1;
			want_q[i] <= want[i];
		end
	end

	always_comb
	begin
		for (int i = 0; i < 2; i++)
			btn[i] = (cnt[i] != 2'h0) ? cnt[i][0] : want_q[i];
	end
endmodule : rpi_operator_model

// >>> test/rpi_top_tb.sv
// Self-checking bench for the relay panel block
`timescale 1ns/100ps
module rpi_top_tb;
	localparam int DEB = 4;
	logic               clk              = 1'b0;
	logic               reset            = 1'b1;
	logic               wr               = 1'b0;
	logic               rd               = 1'b0;
	logic               want_step        = 1'b0;
	logic               want_reset       = 1'b0;
	logic [7:0]         addr             = 8'h00;
	logic [31:0]        wdata            = 32'h0;
	logic               start_lo         = 1'b0;
	logic               trip_lo          = 1'b0;
	logic               start_hi         = 1'b0;
	logic               trip_hi          = 1'b0;
	logic [9:0]         residual_voltage = 10'h0;
	logic [9:0]         neutral_current  = 10'h0;
	logic signed [10:0] dir_current      = 11'sh0;
	logic [31:0]        rdata;
	logic [9:0]         disp_value;
	logic               step_btn, reset_btn, trip_out, erase_mem, disp_minus, disp_overflow;
	logic [3:0]         ind_led;
	logic [2:0]         ar_start_route, quantity_led;
	logic [4:0]         block_route;
	int                 n_errors = 0;
	int                 num_checks = 0;
	int                 n_erase = 0;

	always #12.5 clk = ~clk;

	rpi_operator_model OP (.clk, .want_step, .want_reset, .step_btn, .reset_btn);

	rpi_top #(.DEB_CYCLES(DEB)) DUT (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata,
		.step_btn, .reset_btn, .start_lo, .trip_lo, .start_hi, .trip_hi,
		.residual_voltage, .neutral_current, .dir_current, .ind_led, .trip_out,
		.erase_mem, .ar_start_route, .block_route, .disp_value, .disp_minus,
		.disp_overflow, .quantity_led);

	always @(posedge clk)
		if (erase_mem === 1'b1)
			n_erase++;

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd_chk

	// Write then read with no idle cycle between the strobes
	task automatic wr_rd(input logic [7:0] wa, input logic [31:0] d, input logic [7:0] ra,
		input logic [31:0] exp);
		@(posedge clk);
		wr <= 1'b1;
		addr <= wa;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		addr <= ra;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : wr_rd

	// Reset button goes down first so a both-press is well defined
	task automatic push(input logic s, input logic r);
		@(posedge clk);
		want_reset <= r;
		repeat (16) @(posedge clk);
		want_step <= s;
		repeat (16) @(posedge clk);
		want_step <= 1'b0;
		want_reset <= 1'b0;
		tick(16);
	endtask : push

	task automatic events(input logic [3:0] v);
		@(posedge clk);
		{trip_hi, start_hi, trip_lo, start_lo} <= v;
		repeat (2) @(posedge clk);
		{trip_hi, start_hi, trip_lo, start_lo} <= 4'h0;
		tick(3);
	endtask : events

	logic [7:0]  lf [5] = '{8'h00, 8'h04, 8'h02, 8'h00, 8'hF8};
	logic [1:0]  lb [5] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h2};
	logic [1:0]  lt [5] = '{2'h1, 2'h0, 2'h0, 2'h0, 2'h1};
	logic [1:0]  ds [8] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
	logic [10:0] dv [8] = '{11'h019, 11'h01A, 11'h3E8, 11'h7CE, 11'h064, 11'h065,
		11'h79B, 11'h400};
	logic [4:0]  df [8] = '{5'h04, 5'h05, 5'h08, 5'h12, 5'h10, 5'h11, 5'h13, 5'h13};
	logic [9:0]  dx [8] = '{10'h019, 10'h0, 10'h3E8, 10'h032, 10'h064, 10'h0, 10'h0, 10'h0};

	initial
	begin
		int e;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		rd_chk(8'h04, 32'hA);
		rd_chk(8'h08, 32'h0);
		rd_chk(8'h0C, 32'h0);
		rd_chk(8'h20, 32'h0);
		chk(32'(quantity_led), 32'h1);
		for (int m = 0; m < 16; m++)
		begin
			wr_reg(8'h04, 32'(m));
			events(4'hF);
			chk(32'(ind_led), 32'(m));
			push(1'b0, 1'b1);
			chk(32'(ind_led), 32'h0);
		end
		rd_chk(8'h04, 32'hF);
		// Short glitch on reset button
		events(4'hF);
		@(posedge clk);
		want_reset <= 1'b1;
		repeat (2) @(posedge clk);
		want_reset <= 1'b0;
		tick(16);
		chk(32'(ind_led), 32'hF);
		wr_reg(8'h00, 32'h8);
		wr_reg(8'h04, 32'hA);
		for (int i = 0; i < 5; i++)
		begin
			wr_reg(8'h08, 32'(lf[i]));
			events(4'h2);
			chk(32'(trip_out), 32'h1);
			e = n_erase;
			push(lb[i][1], lb[i][0]);
			chk(32'(trip_out), 32'(lt[i]));
			chk(32'(n_erase - e), 32'(lb[i] == 2'h3));
		end
		wr_reg(8'h0C, 32'hA5);
		tick(2);
		chk(32'(ar_start_route), 32'h5);
		chk(32'(block_route), 32'h14);
		wr_reg(8'h10, 32'h3);
		rd_chk(8'h14, 32'hA);
		wr_rd(8'h14, 32'hC, 8'h04, 32'hC);
		wr_reg(8'h10, 32'h4);
		wr_reg(8'h14, 32'h5);
		rd_chk(8'h08, 32'h5);
		wr_reg(8'h10, 32'h0);
		rd_chk(8'h14, 32'h8);
		for (int i = 0; i < 8; i++)
		begin
			wr_reg(8'h18, 32'(ds[i]));
			residual_voltage <= dv[i][9:0];
			neutral_current <= dv[i][9:0];
			dir_current <= $signed(dv[i]);
			tick(3);
			chk(32'({quantity_led, disp_minus, disp_overflow}), 32'(df[i]));
			if (!df[i][0])
				chk(32'(disp_value), 32'(dx[i]));
		end
		end_of_test();
	end

	initial
	begin
		#(20000 * 25);
		n_errors++;
		end_of_test();
	end
endmodule : rpi_top_tb
